//--- rtl/tx_timing_pkg.sv
// Shared constants and types for the transmit system-side timing block
package tx_timing_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam int unsigned REG_ADDR_W   = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_BLOCK    = 4'h4;
  localparam logic [3:0]  REG_STATUS   = 4'h8;

  // ==========================================================================
  // Control register fields
  localparam int unsigned CTRL_W            = 8;
  localparam int unsigned CTRL_STORE_EN     = 0;
  localparam int unsigned CTRL_SYNC_OUT     = 1;
  localparam int unsigned CTRL_SINGLE_MSTR  = 2;
  localparam int unsigned CTRL_E1_MODE      = 3;
  localparam int unsigned CTRL_INSERT_EN    = 4;
  localparam int unsigned CTRL_PIN_MODE_LO  = 5;
  localparam int unsigned CTRL_INTERLEAVED  = 7;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [31:0] BLOCK_RESET       = 32'h0000_0000;

  // ==========================================================================
  // Status register fields
  localparam int unsigned STAT_FRAMES_W     = 16;
  localparam int unsigned STAT_LOADS_W      = 8;
  localparam int unsigned STAT_W            = 24;
  localparam int unsigned STAT_LOADS_LO     = 16;

  // ==========================================================================
  // Frame geometry
  localparam int unsigned BITS_PER_CHAN     = 8;
  localparam int unsigned CHANS_T1          = 24;
  localparam int unsigned CHANS_E1          = 32;
  localparam int unsigned CFG_W             = CTRL_W + CHANS_E1;

  // Function of the channel clock pin
  typedef enum logic [1:0] {
    PIN_IDLE,
    PIN_LSB_CLOCK,
    PIN_GATED
  } chanPinMode_t;

endpackage : tx_timing_pkg

//--- rtl/frame_pos_if.sv
// Bit and channel position carried from the frame counter to its user
`timescale 1ns/100ps
interface frame_pos_if;
  logic [2:0] bitIdx;
  logic [4:0] chanIdx;
  logic       chanLsb;
  logic       frameStart;

  modport counter (output bitIdx, output chanIdx, output chanLsb, output frameStart);
  modport user    (input bitIdx, input chanIdx, input chanLsb, input frameStart);
endinterface : frame_pos_if

//--- rtl/word_crossing.sv
// Toggle-handshake transfer of a quasi-static word between two clocks
`timescale 1ns/100ps
module word_crossing #(
  parameter int unsigned WIDTH = 8
) (
  // Source side
  input  wire logic             clkSrc,
  input  wire logic             rstSrc_n,
  input  wire logic [WIDTH-1:0] srcData,
  // Destination side
  input  wire logic             clkDst,
  input  wire logic             rstDst_n,
  output logic      [WIDTH-1:0] dstData
);
  logic [WIDTH-1:0] sentData, next_sentData, next_dstData;
  logic             reqToggle, next_reqToggle;
  logic             ackMeta, ackSync;
  logic             reqMeta, reqSync, reqSeen;

  if (WIDTH < 1) begin : g_chk
    $error("word_crossing needs WIDTH of at least 1");
  end

  // ==========================================================================
  // Source: launch a new word only when the previous one was acknowledged
  always_comb begin
    next_sentData  = sentData;
    next_reqToggle = reqToggle;
    if ((reqToggle == ackSync) && (srcData != sentData)) begin
      next_sentData  = srcData;
      next_reqToggle = ~reqToggle;
    end
  end

  always_ff @(posedge clkSrc or negedge rstSrc_n) begin
    if (!rstSrc_n) begin
      sentData  <= '0;
      reqToggle <= 1'b0;
      ackMeta   <= 1'b0;
      ackSync   <= 1'b0;
    end else begin
      sentData  <= next_sentData;
      reqToggle <= next_reqToggle;
      ackMeta   <= reqSeen;
      ackSync   <= ackMeta;
    end
  end

  // ==========================================================================
  // Destination: sentData is held stable until the toggle is seen here
  always_comb begin
    next_dstData = dstData;
    if (reqSync != reqSeen) begin
      next_dstData = sentData;
    end
  end

  always_ff @(posedge clkDst or negedge rstDst_n) begin
    if (!rstDst_n) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
      reqSeen <= 1'b0;
      dstData <= '0;
    end else begin
      reqMeta <= reqToggle;
      reqSync <= reqMeta;
      reqSeen <= reqSync;
      dstData <= next_dstData;
    end
  end

endmodule // word_crossing

//--- rtl/frame_counter.sv
// Bit and channel counter over one transmit frame
`timescale 1ns/100ps
module frame_counter (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Control
  input  wire logic   e1Mode,
  input  wire logic   frameLoad,
  // Position
  frame_pos_if.counter pos
);
  logic [2:0] bitIdx, next_bitIdx;
  logic [4:0] chanIdx, next_chanIdx;
  logic [4:0] lastChan;

  // ==========================================================================
  // Advance one bit per clock, wrap at frame end, jump to zero on a load
  always_comb begin
    lastChan     = e1Mode ? 5'(tx_timing_pkg::CHANS_E1 - 1) : 5'(tx_timing_pkg::CHANS_T1 - 1);
    next_bitIdx  = bitIdx + 3'h1;
    next_chanIdx = chanIdx;
    if (bitIdx == 3'(tx_timing_pkg::BITS_PER_CHAN - 1)) begin
      next_chanIdx = (chanIdx >= lastChan) ? 5'h00 : chanIdx + 5'h01;
    end
    if (frameLoad) begin
      next_bitIdx  = 3'h0;
      next_chanIdx = 5'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitIdx  <= 3'h0;
      chanIdx <= 5'h00;
    end else begin
      bitIdx  <= next_bitIdx;
      chanIdx <= next_chanIdx;
    end
  end

  // Derived position flags
  assign pos.bitIdx     = bitIdx;
  assign pos.chanIdx    = chanIdx;
  assign pos.chanLsb    = (bitIdx == 3'(tx_timing_pkg::BITS_PER_CHAN - 1));
  assign pos.frameStart = (bitIdx == 3'h0) && (chanIdx == 5'h00);

endmodule // frame_counter

//--- rtl/tx_system_side_timing.sv
// Transmit system-side timing of one port: sync pins, signaling, channel pins
// Overview of operation
// - Store on and sync pin input: a pulse on it marks the frame boundary.
// - The shared sync input sets the boundary for every transmitter at once.
// - Store on and sync pin output: drive an 8 kHz frame pulse.
// - The shared sync pin runs synchronous to the transmit system clock.
// - Single-master bit set: use only the shared pin; clear: shared pin unused.
// - Insertion enabled: signaling input bits replace bits of the PCM stream.
// - Signaling sampled on falling edge of the line or system clock.
// - Channel block output is high or low per channel as programmed.
// - Channel pins timed from line clock, or system clock when store is on.
// - Channel clock pulses high during each channel LSB: 192 or 256 kHz.
// - Channel clock pin may instead copy the channel block level, as the bit clock gate.
// - Per-port sync pin used with store on, synchronous to system clock.
`timescale 1ns/100ps
module tx_system_side_timing (
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Transmit timing clock and its source select
  input  wire logic        txTimingClock,
  output logic             txClockSelect,
  // Per-port sync pin
  input  wire logic        txSyncPortIn,
  output logic             txSyncPortOut,
  output logic             txSyncPortOe,
  // Shared sync pin
  input  wire logic        txSyncSharedIn,
  output logic             txSyncSharedOut,
  output logic             txSyncSharedOe,
  // Signaling and PCM stream
  input  wire logic        txSignalingIn,
  input  wire logic        txPcmIn,
  output logic             txPcmOut,
  // Channel pins
  output logic             txChannelBlock,
  output logic             txChannelClock
);
  // ==========================================================================
  // Register file on clk_sys
  logic [7:0]  ctrl, next_ctrl;
  logic [31:0] blockMask, next_blockMask;
  logic [31:0] next_regRdata;
  logic        next_txClockSelect;
  logic [tx_timing_pkg::STAT_W-1:0] statusSys;

  // Writes decode the address; unmapped reads return zero
  always_comb begin
    next_ctrl          = ctrl;
    next_blockMask     = blockMask;
    next_regRdata      = 32'h0000_0000;
    next_txClockSelect = ctrl[tx_timing_pkg::CTRL_STORE_EN];
    if (regWrite) begin
      unique case (regAddr)
        tx_timing_pkg::REG_CTRL:  next_ctrl      = regWdata[7:0];
        tx_timing_pkg::REG_BLOCK: next_blockMask = regWdata;
        default:                  next_ctrl      = ctrl;
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        tx_timing_pkg::REG_CTRL:   next_regRdata = {24'h00_0000, ctrl};
        tx_timing_pkg::REG_BLOCK:  next_regRdata = blockMask;
        tx_timing_pkg::REG_STATUS: next_regRdata = {8'h00, statusSys};
        default:                   next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl          <= tx_timing_pkg::CTRL_RESET;
      blockMask     <= tx_timing_pkg::BLOCK_RESET;
      regRdata      <= 32'h0000_0000;
      txClockSelect <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      blockMask     <= next_blockMask;
      regRdata      <= next_regRdata;
      txClockSelect <= next_txClockSelect;
    end
  end

  // ==========================================================================
  // Link reset: asserted at once, released on the timing clock
  logic linkRstMeta, linkReset_n;

  always_ff @(posedge txTimingClock or negedge reset_n) begin
    if (!reset_n) begin
      linkRstMeta <= 1'b0;
      linkReset_n <= 1'b0;
    end else begin
      linkRstMeta <= 1'b1;
      linkReset_n <= linkRstMeta;
    end
  end

  // ==========================================================================
  // Configuration and status crossings
  logic [tx_timing_pkg::CFG_W-1:0]  cfgLink;
  logic [tx_timing_pkg::STAT_W-1:0] statusLink;

  word_crossing #(.WIDTH(tx_timing_pkg::CFG_W)) u_cfgCross (
    .clkSrc   (clk_sys),
    .rstSrc_n (reset_n),
    .srcData  ({blockMask, ctrl}),
    .clkDst   (txTimingClock),
    .rstDst_n (linkReset_n),
    .dstData  (cfgLink)
  );

  word_crossing #(.WIDTH(tx_timing_pkg::STAT_W)) u_statCross (
    .clkSrc   (txTimingClock),
    .rstSrc_n (linkReset_n),
    .srcData  (statusLink),
    .clkDst   (clk_sys),
    .rstDst_n (reset_n),
    .dstData  (statusSys)
  );

  // Configuration fields as seen by the link logic
  logic         storeEn, syncOutMode, singleMaster, e1Mode, insertEn;
  typedef tx_timing_pkg::chanPinMode_t chanPinSel_t;
  logic [31:0]  cfgMask;
  chanPinSel_t  pinMode;

  assign storeEn      = cfgLink[tx_timing_pkg::CTRL_STORE_EN];
  assign syncOutMode  = cfgLink[tx_timing_pkg::CTRL_SYNC_OUT];
  assign singleMaster = cfgLink[tx_timing_pkg::CTRL_SINGLE_MSTR];
  assign e1Mode       = cfgLink[tx_timing_pkg::CTRL_E1_MODE];
  assign insertEn     = cfgLink[tx_timing_pkg::CTRL_INSERT_EN];
  assign pinMode      = chanPinSel_t'(cfgLink[tx_timing_pkg::CTRL_PIN_MODE_LO +: 2]);
  assign cfgMask      = cfgLink[tx_timing_pkg::CTRL_W +: tx_timing_pkg::CHANS_E1];

  // ==========================================================================
  // Sync input: pin is synchronous to the timing clock, so one flop suffices
  logic syncInQ, syncInPrev, next_syncInQ, frameLoad;

  assign next_syncInQ = singleMaster ? txSyncSharedIn : txSyncPortIn;
  // Shared pulse loads this port like every other port sharing the pin
  assign frameLoad = storeEn && !syncOutMode && syncInQ && !syncInPrev;

  always_ff @(posedge txTimingClock or negedge linkReset_n) begin
    if (!linkReset_n) begin
      syncInQ    <= 1'b0;
      syncInPrev <= 1'b0;
    end else begin
      syncInQ    <= next_syncInQ;
      syncInPrev <= syncInQ;
    end
  end

  // ==========================================================================
  // Frame position
  frame_pos_if pos ();

  frame_counter u_counter (
    .clk       (txTimingClock),
    .rst_n     (linkReset_n),
    .e1Mode    (e1Mode),
    .frameLoad (frameLoad),
    .pos       (pos.counter)
  );

  // ==========================================================================
  // Signaling taken on the falling edge: half a period of setup before use
  logic sigFall;

  always_ff @(negedge txTimingClock or negedge linkReset_n) begin
    if (!linkReset_n) begin
      sigFall <= 1'b0;
    end else begin
      sigFall <= txSignalingIn;
    end
  end

  // ==========================================================================
  // Registered pin outputs and status counters
  logic blockNow, syncDrive;
  logic next_pcmOut, next_block, next_chanClk, next_syncPortOut, next_syncSharedOut;
  logic next_syncPortOe, next_syncSharedOe;
  logic [tx_timing_pkg::STAT_FRAMES_W-1:0] frameCount, next_frameCount;
  logic [tx_timing_pkg::STAT_LOADS_W-1:0]  loadCount, next_loadCount;

  assign blockNow  = cfgMask[pos.chanIdx];
  assign syncDrive = storeEn && syncOutMode;

  always_comb begin
    next_pcmOut        = (insertEn && pos.chanLsb) ? sigFall : txPcmIn;
    next_block         = blockNow;
    next_syncPortOe    = syncDrive && !singleMaster;
    next_syncSharedOe  = syncDrive && singleMaster;
    next_syncPortOut   = next_syncPortOe && pos.frameStart;
    next_syncSharedOut = next_syncSharedOe && pos.frameStart;
    next_frameCount    = pos.frameStart ? frameCount + 16'h0001 : frameCount;
    next_loadCount     = frameLoad ? loadCount + 8'h01 : loadCount;
    unique case (pinMode)
      tx_timing_pkg::PIN_LSB_CLOCK: next_chanClk = pos.chanLsb;
      tx_timing_pkg::PIN_GATED:     next_chanClk = blockNow;
      tx_timing_pkg::PIN_IDLE:      next_chanClk = 1'b0;
      default:                      next_chanClk = 1'b0;
    endcase
  end

  always_ff @(posedge txTimingClock or negedge linkReset_n) begin
    if (!linkReset_n) begin
      txPcmOut        <= 1'b0;
      txChannelBlock  <= 1'b0;
      txChannelClock  <= 1'b0;
      txSyncPortOut   <= 1'b0;
      txSyncPortOe    <= 1'b0;
      txSyncSharedOut <= 1'b0;
      txSyncSharedOe  <= 1'b0;
      frameCount      <= 16'h0000;
      loadCount       <= 8'h00;
    end else begin
      txPcmOut        <= next_pcmOut;
      txChannelBlock  <= next_block;
      txChannelClock  <= next_chanClk;
      txSyncPortOut   <= next_syncPortOut;
      txSyncPortOe    <= next_syncPortOe;
      txSyncSharedOut <= next_syncSharedOut;
      txSyncSharedOe  <= next_syncSharedOe;
      frameCount      <= next_frameCount;
      loadCount       <= next_loadCount;
    end
  end

  assign statusLink = {loadCount, frameCount};

  // ==========================================================================
  // Checks on the timing clock, and the clock select check on clk_sys
  chk_sync_load: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    frameLoad |=> (pos.bitIdx == 3'h0) && (pos.chanIdx == 5'h00))
    else $error("frame counter not loaded by sync pulse");

  chk_sync_pulse: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (pos.frameStart && syncDrive) |=> (txSyncPortOut || txSyncSharedOut) ##1
      (!txSyncPortOut && !txSyncSharedOut))
    else $error("frame sync output pulse wrong");

  chk_shared_only: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    ##1 ($past(singleMaster) ? !txSyncPortOe : !txSyncSharedOe))
    else $error("wrong sync pin enabled");

  chk_insert_lsb: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (insertEn && pos.chanLsb) |=> (txPcmOut == $past(sigFall)))
    else $error("signaling bit not inserted");

  chk_pcm_pass: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (!insertEn || !pos.chanLsb) |=> (txPcmOut == $past(txPcmIn)))
    else $error("PCM bit altered outside insertion");

  chk_block_follow: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    ##1 (txChannelBlock == $past(blockNow)))
    else $error("channel block output wrong");

  chk_lsb_clock: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (pinMode == tx_timing_pkg::PIN_LSB_CLOCK) |=> (txChannelClock == $past(pos.chanLsb)))
    else $error("channel clock pulse wrong");

  chk_gated_clock: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (pinMode == tx_timing_pkg::PIN_GATED) |=> (txChannelClock == $past(blockNow)))
    else $error("gated clock enable wrong");

  chk_t1_wrap: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (!e1Mode && pos.chanIdx == 5'd23 && pos.chanLsb) |=> pos.frameStart)
    else $error("T1 frame did not wrap after 24 channels");

  chk_e1_wrap: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    (e1Mode && pos.chanIdx == 5'h1f && pos.chanLsb) |=> pos.frameStart)
    else $error("E1 frame did not wrap after 32 channels");

  chk_lsb_spacing: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    pos.chanLsb |=> !pos.chanLsb)
    else $error("channel LSB marked on two bits in a row");

  chk_oe_store: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    ##1 ((txSyncPortOe || txSyncSharedOe) == $past(syncDrive)))
    else $error("sync pin driven without store and output mode");

  chk_sync_quiet: assert property (@(posedge txTimingClock) disable iff (!linkReset_n)
    !syncDrive |=> (!txSyncPortOut && !txSyncSharedOut))
    else $error("sync pulse driven while pin is an input");

  chk_clock_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 (txClockSelect == $past(ctrl[tx_timing_pkg::CTRL_STORE_EN])))
    else $error("timing clock select does not follow store enable");

  cov_sync_load: cover property (@(posedge txTimingClock) disable iff (!linkReset_n)
    frameLoad);
  cov_sync_out: cover property (@(posedge txTimingClock) disable iff (!linkReset_n)
    txSyncSharedOut);
  cov_insert: cover property (@(posedge txTimingClock) disable iff (!linkReset_n)
    insertEn && pos.chanLsb);
  cov_e1_wrap: cover property (@(posedge txTimingClock) disable iff (!linkReset_n)
    e1Mode && pos.chanIdx == 5'd31 && pos.chanLsb);
  cov_gated_block: cover property (@(posedge txTimingClock) disable iff (!linkReset_n)
    pinMode == tx_timing_pkg::PIN_GATED && blockNow);

endmodule // tx_system_side_timing

//--- verification/backplane_model.sv
// Behavioural backplane logic facing one transmit port
`timescale 1ns/100ps
module backplane_model (
  // Link clock made by the backplane
  output logic linkClk,
  // Streams towards the port
  output logic pcmBit,
  output logic sigBit,
  // Sync pulses towards the per-port and shared pins
  output logic syncPort,
  output logic syncShared
);
  // ==========================================================================
  // Clock
  // System clock runs free, so it does not stop between frames
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  // ==========================================================================
  // Streams
  // Starting levels; sync and signaling pins idle low, the PCM pin idles high
  initial begin
    pcmBit     = 1'b1;
    sigBit     = 1'b0;
    syncPort   = 1'b0;
    syncShared = 1'b0;
  end

  // One-cycle frame pulse, launched just after a rising edge
  task automatic pulse(input logic shared);
    @(posedge linkClk);
    if (shared) begin
      syncShared <= 1'b1;
    end else begin
      syncPort <= 1'b1;
    end
    @(posedge linkClk);
    syncPort   <= 1'b0;
    syncShared <= 1'b0;
  endtask

  // Signaling level and its inverse on PCM, so an insertion is visible
  task automatic levels(input logic sig);
    @(posedge linkClk);
    sigBit <= sig;
    pcmBit <= ~sig;
  endtask
endmodule // backplane_model

//--- verification/tx_system_side_timing_tb_top.sv
// Self-checking testbench for the transmit system-side timing block
`timescale 1ns/100ps
module tx_system_side_timing_tb_top;
  // ==========================================================================
  // Signals
  localparam logic [31:0] BLOCK_PAT = 32'h0000_0005;
  logic        clk_sys;
  logic        reset_n;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        linkClk;
  logic        txClockSelect;
  logic        portOut;
  logic        portOe;
  logic        sharedOut;
  logic        sharedOe;
  logic        bpPort;
  logic        bpShared;
  logic        pcmBit;
  logic        sigBit;
  logic        txPcmOut;
  logic        txChannelBlock;
  logic        txChannelClock;
  logic [31:0] w;
  logic [31:0] ctrl;
  logic [7:0]  loads;
  logic [1:0]  md;
  logic        e1;
  int          numErrors;
  int          checkCount;

  // ==========================================================================
  // Instances
  backplane_model bp (
    .linkClk(linkClk), .pcmBit(pcmBit), .sigBit(sigBit),
    .syncPort(bpPort), .syncShared(bpShared)
  );

  // Pin level: the design wins while its enable is high
  tx_system_side_timing dut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata),
    .txTimingClock(linkClk), .txClockSelect(txClockSelect),
    .txSyncPortIn(portOe ? portOut : bpPort), .txSyncPortOut(portOut),
    .txSyncPortOe(portOe),
    .txSyncSharedIn(sharedOe ? sharedOut : bpShared), .txSyncSharedOut(sharedOut),
    .txSyncSharedOe(sharedOe),
    .txSignalingIn(sigBit), .txPcmIn(pcmBit), .txPcmOut(txPcmOut),
    .txChannelBlock(txChannelBlock), .txChannelClock(txChannelClock)
  );

  // ==========================================================================
  // Clock, watchdog and verdict
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run needs well under 100 us of link traffic
  initial begin
    #500us;
    numErrors++;
    summarize();
  end

  task automatic summarize();
    if (numErrors == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmpPin(input logic got, input logic exp, input string what);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // ==========================================================================
  // Register port tasks: one-cycle strobes, read data the cycle after
  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic regRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // Config crosses by handshake, so give it many link cycles
  task automatic settle();
    repeat (20) @(posedge linkClk);
  endtask

  // ==========================================================================
  // Link-side checks
  // Pulse taken at edge k puts position 0 on the pins after edge k+2
  task automatic checkFrame(input logic isE1, input logic [1:0] mode);
    int frameLen;
    int chan;
    int bitPos;
    frameLen = isE1 ? 256 : 192;
    @(posedge linkClk);
    for (int j = 0; j < 200; j++) begin
      @(posedge linkClk);
      #1;
      chan   = (j % frameLen) / 8;
      bitPos = j % 8;
      if (j < 24 || j >= 192) begin
        cmpPin(txChannelBlock, BLOCK_PAT[chan], "block");
        cmpPin(txChannelClock, (mode == 2'd1) ? (bitPos == 7) :
               (mode == 2'd2) ? BLOCK_PAT[chan] : 1'b0, "chclk");
        cmpPin(txPcmOut, (mode != 2'd0 && bitPos == 7) ? sigBit : pcmBit, "pcm");
      end
    end
  endtask

  // Frame pulse spacing on the selected sync output, and both sync output enables
  task automatic checkSyncOut(input logic shared, input int expLen);
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge linkClk);
      #1;
      if ((shared ? sharedOut : portOut) === 1'b1) break;
    end
    for (n = 1; n < 600; n++) begin
      @(posedge linkClk);
      #1;
      if ((shared ? sharedOut : portOut) === 1'b1) break;
    end
    cmpWord(32'(n), 32'(expLen), "sync period");
    cmpPin(shared ? sharedOe : portOe, 1'b1, "sync oe");
    cmpPin(shared ? portOe : sharedOe, 1'b0, "other oe");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    reset_n    = 1'b0;
    regAddr    = 4'h0;
    regWdata   = 32'h0000_0000;
    regWrite   = 1'b0;
    regRead    = 1'b0;
    numErrors  = 0;
    checkCount = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    regRd(tx_timing_pkg::REG_CTRL, w);
    cmpWord(w, 32'h0000_0000, "ctrl reset");
    regRd(tx_timing_pkg::REG_BLOCK, w);
    cmpWord(w, tx_timing_pkg::BLOCK_RESET, "block reset");
    regRd(4'hc, w);
    cmpWord(w, 32'h0000_0000, "unmapped read");
    cmpPin(txClockSelect, 1'b0, "clock select reset");
    cmpPin(portOe, 1'b0, "port oe reset");
    regWr(tx_timing_pkg::REG_BLOCK, BLOCK_PAT);
    regRd(tx_timing_pkg::REG_BLOCK, w);
    cmpWord(w, BLOCK_PAT, "block readback");
    // Every pin mode in T1 and E1; E1 runs use the shared sync pin
    for (int m = 0; m < 6; m++) begin
      e1   = m[0];
      md   = 2'(m / 2);
      ctrl = {24'h0, 1'b0, md, md != 2'd0, e1, e1, 1'b0, 1'b1};
      regWr(tx_timing_pkg::REG_CTRL, ctrl);
      bp.levels(m[1]);
      settle();
      regRd(tx_timing_pkg::REG_CTRL, w);
      cmpWord(w, ctrl, "ctrl readback");
      cmpPin(txClockSelect, 1'b1, "clock select");
      regRd(tx_timing_pkg::REG_STATUS, w);
      loads = w[23:16];
      bp.pulse(!e1);
      settle();
      bp.pulse(e1);
      checkFrame(e1, md);
      regRd(tx_timing_pkg::REG_STATUS, w);
      cmpWord({24'h0, w[23:16]}, {24'h0, loads + 8'h01}, "sync loads");
    end
    // Store off: sync input is not a boundary
    regWr(tx_timing_pkg::REG_CTRL, 32'h0000_0000);
    settle();
    cmpPin(txClockSelect, 1'b0, "clock select off");
    regRd(tx_timing_pkg::REG_STATUS, w);
    loads = w[23:16];
    bp.pulse(1'b0);
    settle();
    regRd(tx_timing_pkg::REG_STATUS, w);
    cmpWord({24'h0, w[23:16]}, {24'h0, loads}, "store off load");
    // Sync pins as outputs, per-port in T1 then shared in E1
    regWr(tx_timing_pkg::REG_CTRL, {24'h0, 8'h03});
    settle();
    checkSyncOut(1'b0, 192);
    regWr(tx_timing_pkg::REG_CTRL, {24'h0, 8'h0f});
    settle();
    checkSyncOut(1'b1, 256);
    summarize();
  end
endmodule // tx_system_side_timing_tb_top
